// ===== afr_pkg.sv
// Shared constants and types for the amplifier fault report controller
`default_nettype none

package afr_pkg;

    // ************************************************
    // Clock and timing
    // ************************************************
    localparam int unsigned CLK_FREQ_HZ = 10_000_000; // System clock rate
    localparam int unsigned POWERUP_HOLD_MS = 200; // Reset line hold after power up
    localparam int unsigned POWERUP_HOLD_CYCLES = POWERUP_HOLD_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned RAMP_STEP_US = 10; // Time per volume step
    localparam int unsigned RAMP_STEP_CYCLES = RAMP_STEP_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int unsigned SOFT_RST_HOLD_US = 100; // Silent time in soft reset
    localparam int unsigned SOFT_RST_HOLD_CYCLES = SOFT_RST_HOLD_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int unsigned HOLD_CNT_W = 21; // Fits the power-up hold count
    localparam int unsigned STEP_CNT_W = 10; // Fits ramp and soft reset counts

    // ************************************************
    // Widths and stage allocation
    // ************************************************
    localparam int unsigned NUM_STAGES = 8; // Power stages on the board
    localparam int unsigned VOL_W = 8; // Volume word width
    localparam int unsigned LANES = 4; // Serial audio data lanes
    localparam int unsigned SAMPLE_W = 24; // Bits kept per lane word
    localparam int unsigned FIFO_DEPTH = 8; // Audio words buffered
    // Stage order: FL, FR, RL, RR, SL, SR, C, SUB
    localparam logic [7:0] PRIMARY_MASK = 8'h43; // Front left, front right, center
    localparam logic [7:0] SECONDARY_MASK = 8'hBC; // Rears, surrounds, subwoofer
    localparam logic [2:0] STAGE_MODE_AUTO = 3'h0; // All mode pins low
    localparam logic [VOL_W-1:0] VOL_RESET = 8'h00; // Volume after reset

    // ************************************************
    // Synchroniser vector layout
    // ************************************************
    localparam int unsigned SY_OTW = 0; // Eight stage warnings
    localparam int unsigned SY_SD = 8; // Eight stage shutdowns
    localparam int unsigned SY_RST = 16; // System reset line
    localparam int unsigned SY_MUTE = 17; // Mute pin
    localparam int unsigned SY_BKND = 18; // Soft reset pin
    localparam int unsigned SY_PDN = 19; // Power down pin
    localparam int unsigned SY_CONF = 20; // Speaker or line out select
    localparam int unsigned SY_HP = 21; // Headphone select
    localparam int unsigned SY_SCLK = 22; // Bit clock
    localparam int unsigned SY_LRCLK = 23; // Left-right clock
    localparam int unsigned SY_LANE = 24; // Four data lanes
    localparam int unsigned SYNC_W = 28; // Total synchronised bits
    // Idle pin levels held in reset, so no false edge follows its release
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 28'h020FFFF;

    // ************************************************
    // Types
    // ************************************************
    // Encoded as {warning_n, shutdown_n}
    typedef enum logic [1:0] {
        COND_ERROR = 2'h0,
        COND_WARN = 2'h1,
        COND_UVLO_OC = 2'h2,
        COND_NORMAL = 2'h3
    } afr_cond_t;

    // Volume sequencer states, Gray along the path
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_MUTING = 3'h1,
        ST_MUTED = 3'h3,
        ST_SOFT_RST = 3'h2,
        ST_PWR_DOWN = 3'h6
    } afr_state_t;

    // Merged fault lines, all active low
    typedef struct packed {
        logic warn_n;
        logic pri_n;
        logic sec_n;
    } afr_fault_t;

    // One audio frame half across the four lanes
    typedef struct packed {
        logic right;
        logic [LANES-1:0][SAMPLE_W-1:0] lane;
    } afr_audio_t;

    localparam int unsigned AUDIO_W = $bits(afr_audio_t); // FIFO word width

endpackage : afr_pkg

`default_nettype wire

// ===== afr_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`default_nettype none

module afr_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // Storage
    logic [AW:0] wr_ptr; // Write pointer with wrap bit
    logic [AW:0] rd_ptr; // Read pointer with wrap bit
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic push; // Word accepted
    logic pop; // Word delivered
    logic full;
    logic empty;

    // ************************************************
    // Flags and pointer updates
    // ************************************************
    always_comb begin
        empty = (wr_ptr == rd_ptr);
        full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
        in_ready = !full;
        out_valid = !empty;
        push = in_valid && !full;
        pop = out_ready && !empty;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        out_data = mem[rd_ptr[AW-1:0]];
    end

    // Pointer registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage write, no reset needed
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

endmodule : afr_fifo

`default_nettype wire

// ===== afr_ctrl.sv
// Fault merging, decode, control pins and audio capture for the amplifier board
//
// Behaviour
// - Warning and shutdown pair decode device condition
// - Primary: front pair, center; secondary: the rest
// - Group shutdowns wired-OR of active-low stage lines
// - All stage warnings wired-OR onto one line
// - Mode inputs low: stages auto-recover, pulse briefly
// - Mute pin or command ramps volume to silence
// - Soft reset is quiet, keeps stored volume
// - Power down request enters power-down state
// - Select high: speakers 5-6 on, line out off
// - Headphone active while select is low
// - Four lanes carry pairs, shared clocks
`default_nettype none

module afr_ctrl #(
    parameter int unsigned POWERUP_HOLD = afr_pkg::POWERUP_HOLD_CYCLES
) (
    // Clock (master clock) and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Per-stage fault pins, active low
    input wire logic [afr_pkg::NUM_STAGES-1:0] stage_otw_n,
    input wire logic [afr_pkg::NUM_STAGES-1:0] stage_sd_n,
    // Stage mode pins
    output logic stage_mode_a,
    output logic stage_mode_b,
    output logic stage_mode_c,
    // Merged open-drain lines: output value and enable (low drives)
    output logic over_temp_warning_n_o,
    output logic over_temp_warning_n_oe_n,
    output logic primary_group_shutdown_n_o,
    output logic primary_group_shutdown_n_oe_n,
    output logic secondary_group_shutdown_n_o,
    output logic secondary_group_shutdown_n_oe_n,
    // Decoded conditions
    output afr_pkg::afr_cond_t primary_cond,
    output afr_pkg::afr_cond_t secondary_cond,
    // Bidirectional system reset line
    input wire logic sys_reset_n_i,
    output logic sys_reset_n_o,
    output logic sys_reset_n_oe_n,
    // Controller pins
    input wire logic mute,
    input wire logic backend_soft_reset,
    input wire logic power_down_req,
    input wire logic speaker_lineout_select,
    input wire logic headphone_select_n,
    // Command side, same clock
    input wire logic mute_cmd,
    input wire logic vol_wr,
    input wire logic [afr_pkg::VOL_W-1:0] vol_wr_data,
    // Output path status
    output logic [afr_pkg::VOL_W-1:0] volume,
    output logic muted,
    output logic pwm_power_down,
    output logic speaker_ch56_enable,
    output logic line_out_enable,
    output logic headphone_enable,
    // Serial audio pins
    input wire logic audio_bit_clk,
    input wire logic audio_lr_clk,
    input wire logic audio_lane_0,
    input wire logic audio_lane_1,
    input wire logic audio_lane_2,
    input wire logic audio_lane_3,
    // Captured audio stream
    output logic audio_valid,
    input wire logic audio_ready,
    output afr_pkg::afr_audio_t audio_data,
    output logic audio_overrun
);
    import afr_pkg::*;

    // ************************************************
    // Declarations
    // ************************************************
    logic [SYNC_W-1:0] sync_a; // First stage, read only by sync_b
    logic [SYNC_W-1:0] sync_b; // Second stage, safe to use
    logic [SYNC_W-1:0] next_sync_a;
    logic [SYNC_W-1:0] next_sync_b;
    afr_fault_t fault; // Merged lines
    afr_fault_t next_fault;
    afr_state_t state; // Volume sequencer
    afr_state_t next_state;
    logic [VOL_W-1:0] vol_setting; // Stored volume, kept over soft reset
    logic [VOL_W-1:0] next_vol_setting;
    logic [VOL_W-1:0] next_volume;
    logic [STEP_CNT_W-1:0] step_cnt; // Ramp and hold timer
    logic [STEP_CNT_W-1:0] next_step_cnt;
    logic [HOLD_CNT_W-1:0] hold_cnt; // Power-up reset hold
    logic [HOLD_CNT_W-1:0] next_hold_cnt;
    logic bknd_prev; // Soft reset edge detect
    logic next_bknd_prev;
    logic [2:0] sel; // Registered enables
    logic [2:0] next_sel;
    logic sclk_prev; // Bit clock edge detect
    logic lrclk_prev; // Word clock edge detect
    logic next_sclk_prev;
    logic next_lrclk_prev;
    logic [LANES-1:0][SAMPLE_W-1:0] shreg; // Lane shift registers
    logic [LANES-1:0][SAMPLE_W-1:0] next_shreg;
    logic overrun; // Sticky lost-word flag
    logic next_overrun;
    logic push_valid; // Word ready for the FIFO
    logic push_ready; // FIFO can take it
    afr_audio_t push_word;
    logic mute_req; // Pin or command
    logic ramp_tick; // One volume step due
    logic line_reset; // Controller holds reset low

    // ************************************************
    // Input synchronisers
    // ************************************************
    always_comb begin
        next_sync_a = {audio_lane_3, audio_lane_2, audio_lane_1, audio_lane_0,
                       audio_lr_clk, audio_bit_clk, headphone_select_n,
                       speaker_lineout_select, power_down_req, backend_soft_reset,
                       mute, sys_reset_n_i, stage_sd_n, stage_otw_n};
        next_sync_b = sync_a;
    end

    // Two flops on every pin input
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sync_a <= SYNC_IDLE;
            sync_b <= SYNC_IDLE;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // ************************************************
    // Fault merging and decode
    // ************************************************
    always_comb begin
        // Any member stage low pulls its shared line low
        next_fault.warn_n = &sync_b[SY_OTW +: NUM_STAGES];
        next_fault.pri_n = &(sync_b[SY_SD +: NUM_STAGES] | ~PRIMARY_MASK);
        next_fault.sec_n = &(sync_b[SY_SD +: NUM_STAGES] | ~SECONDARY_MASK);
    end

    // Merged line registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            fault <= '1;
        end else begin
            fault <= next_fault;
        end
    end

    // Open drain: drive low only when a line is asserted
    assign over_temp_warning_n_o = 1'b0;
    assign primary_group_shutdown_n_o = 1'b0;
    assign secondary_group_shutdown_n_o = 1'b0;
    assign over_temp_warning_n_oe_n = fault.warn_n;
    assign primary_group_shutdown_n_oe_n = fault.pri_n;
    assign secondary_group_shutdown_n_oe_n = fault.sec_n;
    // Each group has its own condition so the controller can tell them apart
    assign primary_cond = afr_cond_t'({fault.warn_n, fault.pri_n});
    assign secondary_cond = afr_cond_t'({fault.warn_n, fault.sec_n});
    // Auto-recovery: stages restart themselves, shutdown only pulses
    assign {stage_mode_c, stage_mode_b, stage_mode_a} = STAGE_MODE_AUTO;

    // ************************************************
    // Volume sequencer
    // ************************************************
    always_comb begin
        mute_req = sync_b[SY_MUTE] || mute_cmd;
        line_reset = !sync_b[SY_RST];
        ramp_tick = (step_cnt == STEP_CNT_W'(RAMP_STEP_CYCLES - 1));
        next_state = state;
        next_volume = volume;
        next_step_cnt = step_cnt + 1'b1;
        next_bknd_prev = sync_b[SY_BKND];
        // Stored setting survives soft reset, only command writes change it
        next_vol_setting = vol_wr ? vol_wr_data : vol_setting;
        case (state)
            ST_RUN: begin
                // Follow the stored setting one step at a time
                if (ramp_tick) begin
                    next_step_cnt = '0;
                    if (volume < vol_setting) begin
                        next_volume = volume + 1'b1;
                    end else if (volume > vol_setting) begin
                        next_volume = volume - 1'b1;
                    end
                end
                if (sync_b[SY_PDN] || mute_req || (sync_b[SY_BKND] && !bknd_prev)) begin
                    next_state = ST_MUTING;
                    next_step_cnt = '0;
                end
            end
            ST_MUTING: begin
                // Ramp from any setting down to silence
                if (ramp_tick) begin
                    next_step_cnt = '0;
                    if (volume != '0) begin
                        next_volume = volume - 1'b1;
                    end else if (sync_b[SY_PDN]) begin
                        next_state = ST_PWR_DOWN;
                    end else if (sync_b[SY_BKND]) begin
                        next_state = ST_SOFT_RST;
                    end else if (mute_req) begin
                        next_state = ST_MUTED;
                    end else begin
                        next_state = ST_RUN;
                    end
                end
            end
            ST_MUTED: begin
                next_step_cnt = '0;
                if (sync_b[SY_PDN] || sync_b[SY_BKND]) begin
                    next_state = ST_MUTING;
                end else if (!mute_req) begin
                    next_state = ST_RUN;
                end
            end
            ST_SOFT_RST: begin
                // Silent hold, then ramp back to the kept setting
                if (step_cnt == STEP_CNT_W'(SOFT_RST_HOLD_CYCLES - 1)) begin
                    next_step_cnt = '0;
                    if (!sync_b[SY_BKND]) begin
                        next_state = ST_RUN;
                    end
                end
            end
            ST_PWR_DOWN: begin
                next_step_cnt = '0;
                if (!sync_b[SY_PDN]) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_MUTING;
            end
        endcase
        // Controller reset line low: volume cut at once
        if (line_reset) begin
            next_state = ST_MUTED;
            next_volume = '0;
        end
        // Power-up hold counter for driving the reset line
        next_hold_cnt = (hold_cnt == HOLD_CNT_W'(POWERUP_HOLD)) ? hold_cnt : hold_cnt + 1'b1;
        // Output routing selects
        next_sel = {sync_b[SY_CONF], !sync_b[SY_CONF], !sync_b[SY_HP]};
    end

    // Sequencer registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state <= ST_MUTED;
            volume <= VOL_RESET;
            vol_setting <= VOL_RESET;
            step_cnt <= '0;
            hold_cnt <= '0;
            bknd_prev <= 1'b0;
            sel <= '0;
        end else begin
            state <= next_state;
            volume <= next_volume;
            vol_setting <= next_vol_setting;
            step_cnt <= next_step_cnt;
            hold_cnt <= next_hold_cnt;
            bknd_prev <= next_bknd_prev;
            sel <= next_sel;
        end
    end

    assign muted = (state == ST_MUTED) || (state == ST_PWR_DOWN) || (state == ST_SOFT_RST);
    assign pwm_power_down = (state == ST_PWR_DOWN);
    assign speaker_ch56_enable = sel[2];
    assign line_out_enable = sel[1];
    assign headphone_enable = sel[0];
    // Keep the shared reset line low until the power-up hold has run out
    assign sys_reset_n_o = 1'b0;
    assign sys_reset_n_oe_n = (hold_cnt == HOLD_CNT_W'(POWERUP_HOLD));

    // ************************************************
    // Serial audio capture
    // ************************************************
    // Bit clock is oversampled, so it must stay well below half the master clock
    always_comb begin
        next_sclk_prev = sync_b[SY_SCLK];
        next_lrclk_prev = lrclk_prev;
        next_shreg = shreg;
        next_overrun = overrun;
        push_valid = 1'b0;
        push_word.right = lrclk_prev;
        push_word.lane = shreg;
        if (sync_b[SY_SCLK] && !sclk_prev) begin
            // Shared bit clock shifts every lane together
            for (int l = 0; l < LANES; l++) begin
                next_shreg[l] = {shreg[l][SAMPLE_W-2:0], sync_b[SY_LANE + l]};
            end
            // Word clock change closes the half frame
            if (sync_b[SY_LRCLK] != lrclk_prev) begin
                next_lrclk_prev = sync_b[SY_LRCLK];
                push_valid = 1'b1;
                if (!push_ready) begin
                    next_overrun = 1'b1;
                end
            end
        end
    end

    // Capture registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            sclk_prev <= 1'b0;
            lrclk_prev <= 1'b0;
            shreg <= '0;
            overrun <= 1'b0;
        end else begin
            sclk_prev <= next_sclk_prev;
            lrclk_prev <= next_lrclk_prev;
            shreg <= next_shreg;
            overrun <= next_overrun;
        end
    end

    assign audio_overrun = overrun;

    // Buffer between capture and the consumer
    afr_fifo #(
        .WIDTH(AUDIO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_word),
        .out_valid(audio_valid),
        .out_ready(audio_ready),
        .out_data(audio_data)
    );

endmodule : afr_ctrl

`default_nettype wire

// ===== afr_ctrl_monitor.sv
// Port checker for the amplifier fault report controller
`default_nettype none
module afr_ctrl_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Stage pins
    input wire logic [afr_pkg::NUM_STAGES-1:0] stage_otw_n,
    input wire logic [afr_pkg::NUM_STAGES-1:0] stage_sd_n,
    input wire logic stage_mode_a,
    input wire logic stage_mode_b,
    input wire logic stage_mode_c,
    // Merged lines and conditions
    input wire logic over_temp_warning_n_o,
    input wire logic over_temp_warning_n_oe_n,
    input wire logic primary_group_shutdown_n_o,
    input wire logic primary_group_shutdown_n_oe_n,
    input wire logic secondary_group_shutdown_n_o,
    input wire logic secondary_group_shutdown_n_oe_n,
    input wire afr_pkg::afr_cond_t primary_cond,
    input wire afr_pkg::afr_cond_t secondary_cond,
    // Output path
    input wire logic [afr_pkg::VOL_W-1:0] volume,
    input wire logic muted,
    input wire logic pwm_power_down
);
    timeunit 1ns;
    timeprecision 1ns;
    import afr_pkg::*;
    logic [1:0] up; // Edges since reset release
    logic [1:0] next_up;
    // Saturating count keeps $past off pre-reset pins
    always_comb begin
        next_up = !reset_n ? 2'h0 : up + {1'b0, up != 2'h3};
    end
    always_ff @(posedge clk_sys) begin
        up <= next_up;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    property p_mode; {stage_mode_c, stage_mode_b, stage_mode_a} == STAGE_MODE_AUTO; endproperty
    a_mode: assert property (p_mode) else $error("mode pins not low");
    property p_pri; up == 2'h3 |-> primary_group_shutdown_n_oe_n ==
        &($past(stage_sd_n, 3) | ~PRIMARY_MASK); endproperty
    a_pri: assert property (p_pri) else $error("primary merge wrong");
    property p_sec; up == 2'h3 |-> secondary_group_shutdown_n_oe_n ==
        &($past(stage_sd_n, 3) | ~SECONDARY_MASK); endproperty
    a_sec: assert property (p_sec) else $error("secondary merge wrong");
    property p_warn; up == 2'h3 |-> over_temp_warning_n_oe_n == &$past(stage_otw_n, 3);
    endproperty
    a_warn: assert property (p_warn) else $error("warning merge wrong");
    property p_drive; !(over_temp_warning_n_o | primary_group_shutdown_n_o |
        secondary_group_shutdown_n_o); endproperty
    a_drive: assert property (p_drive) else $error("open-drain value high");
    property p_cond; primary_cond == {over_temp_warning_n_oe_n, primary_group_shutdown_n_oe_n}
        && secondary_cond == {over_temp_warning_n_oe_n, secondary_group_shutdown_n_oe_n};
    endproperty
    a_cond: assert property (p_cond) else $error("condition decode wrong");
    property p_mute; $rose(muted) |-> volume == 8'h00; endproperty
    a_mute: assert property (p_mute) else $error("muted before volume zero");
    property p_pdn; pwm_power_down |-> muted && volume == 8'h00; endproperty
    a_pdn: assert property (p_pdn) else $error("power down not silent");
    c_fault: cover property ($fell(primary_group_shutdown_n_oe_n));
    c_mute: cover property ($rose(muted));
    c_pdn: cover property ($rose(pwm_power_down));
endmodule : afr_ctrl_monitor
`default_nettype wire

// ===== afr_i2s_src.sv
// Serial audio source standing in for the controller board
`default_nettype none
module afr_i2s_src (
    // Serial audio pins
    output var logic audio_bit_clk,
    output var logic audio_lr_clk,
    output var logic audio_lane_0,
    output var logic audio_lane_1,
    output var logic audio_lane_2,
    output var logic audio_lane_3
);
    timeunit 1ns;
    timeprecision 1ns;
    // Bit clock still between frames
    initial begin
        audio_bit_clk = 1'b0;
        audio_lr_clk = 1'b1;
        {audio_lane_3, audio_lane_2, audio_lane_1, audio_lane_0} = 4'h0;
    end
    // Sends n bits on every lane, shared clocks, data set while bit clock low
    task automatic send(input int n, input logic lr, input logic [3:0] b);
        repeat (n) begin
            audio_lr_clk = lr;
            {audio_lane_3, audio_lane_2, audio_lane_1, audio_lane_0} = b;
            #400 audio_bit_clk = 1'b1;
            #400 audio_bit_clk = 1'b0;
        end
        // Released lanes show no stale value
        {audio_lane_3, audio_lane_2, audio_lane_1, audio_lane_0} = ~b;
    endtask : send
endmodule : afr_i2s_src
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the amplifier fault report controller
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import afr_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [NUM_STAGES-1:0] stage_otw_n = 8'hFF;
    logic [NUM_STAGES-1:0] stage_sd_n = 8'hFF;
    logic mute = 1'b0, mute_cmd = 1'b0, backend_soft_reset = 1'b0, power_down_req = 1'b0;
    logic speaker_lineout_select = 1'b0, headphone_select_n = 1'b1, line_low = 1'b0;
    logic vol_wr = 1'b0, audio_ready = 1'b0;
    logic [VOL_W-1:0] vol_wr_data = 8'h00;
    logic [VOL_W-1:0] volume;
    logic stage_mode_a, stage_mode_b, stage_mode_c, muted, pwm_power_down, audio_overrun;
    logic over_temp_warning_n_o, over_temp_warning_n_oe_n, sys_reset_n_o, sys_reset_n_oe_n;
    logic primary_group_shutdown_n_o, primary_group_shutdown_n_oe_n;
    logic secondary_group_shutdown_n_o, secondary_group_shutdown_n_oe_n;
    logic speaker_ch56_enable, line_out_enable, headphone_enable, audio_valid;
    logic audio_bit_clk, audio_lr_clk, audio_lane_0, audio_lane_1, audio_lane_2, audio_lane_3;
    afr_cond_t primary_cond, secondary_cond;
    afr_audio_t audio_data;
    int errors = 0;
    int comparisons = 0;
    // Reset line has a pull-up; block or board may pull it low
    wire logic sys_reset_n_i = (sys_reset_n_oe_n | sys_reset_n_o) & !line_low;
    always #50 clk_sys = ~clk_sys;
    afr_ctrl #(.POWERUP_HOLD(20)) dut_u (.*);
    afr_i2s_src src_u (
        .audio_bit_clk, .audio_lr_clk, .audio_lane_0, .audio_lane_1, .audio_lane_2,
        .audio_lane_3
    );
    // Compare and count
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    // Wait n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #10;
    endtask : tick
    // Lane words for a constant bit per lane
    function automatic logic [LANES-1:0][SAMPLE_W-1:0] lanes(input logic [3:0] b);
        for (int i = 0; i < LANES; i++) lanes[i] = {SAMPLE_W{b[i]}};
    endfunction : lanes
    task automatic conclude;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    // Watchdog
    initial begin
        #2_000_000;
        errors++;
        conclude();
    end
    initial begin
        tick(16);
        chk({muted, volume, primary_cond, sys_reset_n_oe_n, sys_reset_n_o},
            {1'b1, 8'h00, COND_NORMAL, 1'b0, 1'b0});
        reset_n = 1'b1;
        tick(40);
        chk(sys_reset_n_oe_n, 1'b1);
        $display("reset test done");
        for (int i = 0; i < NUM_STAGES; i++) begin
            stage_sd_n = ~(8'h01 << i);
            tick(4);
            chk({primary_cond, secondary_cond},
                {1'b1, ~PRIMARY_MASK[i], 1'b1, ~SECONDARY_MASK[i]});
            stage_otw_n = ~(8'h01 << i);
            tick(4);
            chk({over_temp_warning_n_oe_n, primary_cond, secondary_cond},
                {1'b0, 1'b0, ~PRIMARY_MASK[i], 1'b0, ~SECONDARY_MASK[i]});
            stage_sd_n = 8'hFF;
            stage_otw_n = 8'hFF;
            tick(4);
            chk({primary_cond, secondary_cond}, {COND_NORMAL, COND_NORMAL});
        end
        $display("fault test done");
        for (int k = 0; k < 4; k++) begin
            {speaker_lineout_select, headphone_select_n} = k[1:0];
            tick(4);
            chk({speaker_ch56_enable, line_out_enable, headphone_enable},
                {k[1], ~k[1], ~k[0]});
        end
        $display("select test done");
        vol_wr_data = 8'h03;
        vol_wr = 1'b1;
        tick(1);
        vol_wr = 1'b0;
        tick(400);
        chk(volume, 8'h03);
        for (int k = 0; k < 4; k++) begin
            {power_down_req, backend_soft_reset, mute_cmd, mute} = 4'h1 << k;
            tick(450);
            chk({muted, pwm_power_down, volume}, {1'b1, k == 3, 8'h00});
            {power_down_req, backend_soft_reset, mute_cmd, mute} = 4'h0;
            tick(k == 2 ? 1500 : 450);
            chk({muted, pwm_power_down, volume}, {2'b00, 8'h03});
        end
        mute = 1'b1;
        tick(1);
        line_low = 1'b1;
        tick(4);
        chk({muted, volume}, {1'b1, 8'h00});
        {mute, line_low} = 2'b00;
        tick(450);
        chk(volume, 8'h03);
        $display("volume test done");
        src_u.send(24, 1'b0, 4'h5);
        src_u.send(1, 1'b1, 4'h5);
        src_u.send(24, 1'b1, 4'hA);
        for (int k = 0; k < 8; k++) src_u.send(1, k[0], 4'hA);
        tick(4);
        chk(audio_overrun, 1'b1);
        for (int j = 0; j < FIFO_DEPTH; j++) begin
            chk({audio_valid, audio_data.right}, {1'b1, j[0]});
            if (j < 2) chk(audio_data.lane, lanes(j == 0 ? 4'h5 : 4'hA));
            audio_ready = 1'b1;
            tick(1);
            audio_ready = 1'b0;
            tick(1);
        end
        chk(audio_valid, 1'b0);
        $display("audio test done");
        conclude();
    end
endmodule : testbench
bind afr_ctrl afr_ctrl_monitor mon_u (.*);
`default_nettype wire
